// [src/crw_sequencer.sv]
/*
  crw_sequencer: digital sequencing around the on-chip core regulator.
  Assumes synchronous inputs, one 40 MHz clock and an APB master.
*/
`timescale 1ns/1ps
module crw_sequencer
  import crw_pkg::*;
#(
  parameter int SETTLE_CYCLES = SETTLE_CYC,
  parameter int WAKE_SHORT_CYCLES = WAKE_SHORT_CYC,
  parameter int WAKE_LONG_CYCLES = WAKE_LONG_CYC
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic por_n,
  input wire logic regulator_enable_strap,
  input wire crw_evt_t evt,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic exec_enable,
  output logic regulator_on,
  output logic regulator_standby,
  output logic brownout_reset
);

  initial
  begin
    if (SETTLE_CYCLES < 1 || WAKE_SHORT_CYCLES < 1 || WAKE_LONG_CYCLES < 1 ||
        SETTLE_CYCLES >= (1 << CNT_W) || WAKE_LONG_CYCLES >= (1 << CNT_W))
      $error("crw_sequencer: cycle counts out of range");
  end

  // ****************************************
  // registers
  // ****************************************
  crw_state_t state_q, state_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic standby_dis_q, standby_dis_d;
  logic [1:0] wake_sel_q, wake_sel_d;
  logic low_volt_q, low_volt_d;
  logic brown_q, brown_d;
  logic bor_pulse_q, bor_pulse_d;
  logic strap_q, strap_d;
  logic [31:0] prdata_d;
  logic pready_q, pready_d;
  logic pslverr_d;

  logic wr, rd, hit, do_clr_lv, do_clr_bo;
  logic exec_d, reg_on_d, reg_standby_d;

  function automatic logic [CNT_W-1:0] wake_cycles(input logic [1:0] sel);
    // short only for 01; other codes take the long, safe interval
    if (sel == WAKE_SEL_SHORT)
      return CNT_W'(WAKE_SHORT_CYCLES);
    else
      return CNT_W'(WAKE_LONG_CYCLES);
  endfunction : wake_cycles

  // ****************************************
  // apb decode
  // ****************************************
  always_comb
  begin
    // write lands at the access edge, where pready is seen high
    wr = psel && penable && pwrite && pready_q;
    rd = psel && !penable;
    hit = (paddr == RESET_CTRL_OFS) || (paddr == INT_FLAG4_OFS) ||
          (paddr == CFG_WORD3_OFS) || (paddr == STATUS_OFS);
    do_clr_bo = wr && paddr == RESET_CTRL_OFS && !pwdata[BROWNOUT_BIT];
    do_clr_lv = wr && paddr == INT_FLAG4_OFS && !pwdata[LOW_VOLT_BIT];
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    standby_dis_d = standby_dis_q;
    wake_sel_d = wake_sel_q;
    strap_d = regulator_enable_strap;
    bor_pulse_d = 1'b0;
    pready_d = psel && !penable;
    pslverr_d = psel && !penable && !hit;
    prdata_d = prdata;

    // set wins over a same-cycle clear
    low_volt_d = (low_volt_q && !do_clr_lv) || (strap_q && evt.low_volt);
    brown_d = (brown_q && !do_clr_bo) || (strap_q && evt.brownout);

    if (wr && paddr == RESET_CTRL_OFS)
      standby_dis_d = pwdata[STANDBY_DIS_BIT];
    if (wr && paddr == CFG_WORD3_OFS)
      wake_sel_d = pwdata[WAKE_SEL_LSB +: 2];

    if (rd)
    begin
      prdata_d = 32'h0;
      case (paddr)
        RESET_CTRL_OFS:
        begin
          prdata_d[STANDBY_DIS_BIT] = standby_dis_q;
          prdata_d[BROWNOUT_BIT] = brown_q;
        end
        INT_FLAG4_OFS: prdata_d[LOW_VOLT_BIT] = low_volt_q;
        CFG_WORD3_OFS: prdata_d[WAKE_SEL_LSB +: 2] = wake_sel_q;
        STATUS_OFS: prdata_d[2:0] = 3'(state_q);
        default: prdata_d = 32'h0;
      endcase
    end

    case (state_q)
      CRW_OFF:
      begin
        if (strap_q)
        begin
          state_d = CRW_SETTLE;
          cnt_d = CNT_W'(SETTLE_CYCLES);
        end
      end
      CRW_SETTLE, CRW_WAKE:
      begin
        if (cnt_q <= CNT_W'(1))
          state_d = CRW_RUN;
        else
          cnt_d = cnt_q - CNT_W'(1);
      end
      CRW_RUN:
      begin
        if (evt.brownout)
        begin
          bor_pulse_d = 1'b1;
          state_d = CRW_SETTLE;
          cnt_d = CNT_W'(SETTLE_CYCLES);
        end
        else if (evt.sleep_req)
          state_d = CRW_SLEEP;
      end
      CRW_SLEEP:
      begin
        if (evt.wake_evt)
        begin
          if (standby_dis_q)
            state_d = CRW_RUN;
          else
          begin
            state_d = CRW_WAKE;
            cnt_d = wake_cycles(wake_sel_q);
          end
        end
      end
      default: state_d = CRW_OFF;
    endcase

    if (!strap_q)
      state_d = CRW_OFF;
  end

  // ****************************************
  // output next values
  // ****************************************
  always_comb
  begin
    exec_d = (state_d == CRW_RUN);
    reg_on_d = (state_d != CRW_OFF) && !(state_d == CRW_SLEEP && !standby_dis_d);
    reg_standby_d = (state_d == CRW_SLEEP) && !standby_dis_d;
  end

  // ****************************************
  // flops; brown-out flag cleared by power-on or by writing 0 to BROWNOUT_BIT, not by presetn
  // ****************************************
  always_ff @(posedge pclk or negedge por_n)
  begin
    if (!por_n)
      brown_q <= 1'b0;
    else
      brown_q <= brown_d;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= CRW_OFF;
      cnt_q <= '0;
      standby_dis_q <= STANDBY_DIS_RST;
      wake_sel_q <= WAKE_SEL_RST;
      low_volt_q <= 1'b0;
      bor_pulse_q <= 1'b0;
      strap_q <= 1'b0;
      prdata <= 32'h0;
      pready_q <= 1'b0;
      pslverr <= 1'b0;
      exec_enable <= 1'b0;
      regulator_on <= 1'b0;
      regulator_standby <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      standby_dis_q <= standby_dis_d;
      wake_sel_q <= wake_sel_d;
      low_volt_q <= low_volt_d;
      bor_pulse_q <= bor_pulse_d;
      strap_q <= strap_d;
      prdata <= prdata_d;
      pready_q <= pready_d;
      pslverr <= pslverr_d;
      exec_enable <= exec_d;
      regulator_on <= reg_on_d;
      regulator_standby <= reg_standby_d;
    end
  end

  assign pready = pready_q;
  assign brownout_reset = bor_pulse_q;

endmodule : crw_sequencer

// [inc/crw_pkg.sv]
/*
  crw_pkg: constants, register map and carrier types for the core regulator
  wake sequencer. Assumes a 40 MHz pclk and a 32-bit APB slave port.
*/
package crw_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_MHZ = 40;
  localparam int SETTLE_US = 10;
  localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
  // standby wake intervals, short (01) and long (11), in microseconds
  localparam int WAKE_SHORT_US = 10;
  localparam int WAKE_LONG_US = 20;
  localparam int WAKE_SHORT_CYC = WAKE_SHORT_US * CLK_MHZ;
  localparam int WAKE_LONG_CYC = WAKE_LONG_US * CLK_MHZ;
  localparam int CNT_W = 16;

  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [11:0] RESET_CTRL_OFS = 12'h000;
  localparam logic [11:0] INT_FLAG4_OFS = 12'h004;
  localparam logic [11:0] CFG_WORD3_OFS = 12'h008;
  localparam logic [11:0] STATUS_OFS = 12'h00c;

  // ****************************************
  // field positions
  // ****************************************
  localparam int BROWNOUT_BIT = 1;
  localparam int STANDBY_DIS_BIT = 8;
  localparam int LOW_VOLT_BIT = 8;
  localparam int WAKE_SEL_LSB = 10;
  localparam logic [1:0] WAKE_SEL_SHORT = 2'h1;
  localparam logic [1:0] WAKE_SEL_LONG = 2'h3;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic STANDBY_DIS_RST = 1'b0;
  localparam logic [1:0] WAKE_SEL_RST = 2'h3;

  typedef enum logic [2:0] {
    CRW_OFF,
    CRW_SETTLE,
    CRW_RUN,
    CRW_SLEEP,
    CRW_WAKE
  } crw_state_t;

  typedef struct packed {
    logic sleep_req;
    logic wake_evt;
    logic low_volt;
    logic brownout;
  } crw_evt_t;

endpackage : crw_pkg

// [test/crw_assertions.sv]
/* crw_assertions: port checks for crw_sequencer.
   assumes a single pclk domain; bound to every instance below. */
`timescale 1ns/1ps
module crw_assertions
#(
  parameter int SETTLE_CYCLES = 4
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic regulator_enable_strap,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic exec_enable,
  input wire logic regulator_on,
  input wire logic regulator_standby,
  input wire logic brownout_reset
);
  // ****************
  // strap age
  // ****************
  logic [15:0] strap_q;
  logic [15:0] strap_d;
  // saturates, so a long run never wraps
  always_comb strap_d = !regulator_enable_strap ? 16'h0 : (&strap_q) ? strap_q : strap_q + 16'h1;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) strap_q <= 16'h0;
    else strap_q <= strap_d;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ****************
  // checks
  // ****************
  a_settle_first: assert property ($rose(exec_enable) |-> strap_q >= SETTLE_CYCLES)
    else $error("exec before settle");
  a_standby_idle: assert property (regulator_standby |-> !exec_enable && !regulator_on)
    else $error("exec in standby");
  a_exec_powered: assert property (exec_enable |-> regulator_on)
    else $error("exec without regulator");
  a_strap_low_off: assert property (!regulator_enable_strap [*4] |-> !regulator_on)
    else $error("regulator on without strap");
  a_bor_pulse: assert property (brownout_reset |=> !brownout_reset)
    else $error("brownout pulse too long");
  a_bor_resettle: assert property (brownout_reset |=> !exec_enable [*3])
    else $error("no resettle after brownout");
  a_ready_next: assert property (psel && !penable |=> pready)
    else $error("pready late");
  a_ready_once: assert property (pready |=> !pready)
    else $error("pready held");
  a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error read not zero");
endmodule : crw_assertions
bind crw_sequencer crw_assertions #(.SETTLE_CYCLES(SETTLE_CYCLES)) chk_u (
  .pclk(pclk),
  .presetn(presetn),
  .regulator_enable_strap(regulator_enable_strap),
  .psel(psel),
  .penable(penable),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .exec_enable(exec_enable),
  .regulator_on(regulator_on),
  .regulator_standby(regulator_standby),
  .brownout_reset(brownout_reset)
);

// [test/test_crw_sequencer.sv]
/* test_crw_sequencer: directed bench for crw_sequencer.
   assumes short settle parameters and an APB master. */
`timescale 1ns/1ps
module test_crw_sequencer;
  import crw_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, por_n = 1'b0, regulator_enable_strap = 1'b0;
  crw_evt_t evt = '0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, rd, prdata;
  logic pready, pslverr, exec_enable, regulator_on, regulator_standby, brownout_reset;
  int errors = 0, samples_checked = 0, cyc = 0, n;
  always #12.5 pclk = ~pclk;
  crw_sequencer #(.SETTLE_CYCLES(4), .WAKE_SHORT_CYCLES(4), .WAKE_LONG_CYCLES(8)) dut_u (.*);
  // ****************
  // helpers
  // ****************
  task chk(input logic ok, input string m);
    samples_checked++;
    if (ok !== 1'b1) begin errors++; $display("mismatch %0t %s", $time, m); end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk); penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata; er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  // waits for execution, counting cycles in n; the cyc == 5000 watchdog in main guards a hang
  task wexec;
    n = 0;
    while (exec_enable !== 1'b1) begin @(posedge pclk); n++; end
  endtask : wexec
  task pulse_rst(input logic por);
    presetn <= 1'b0; por_n <= !por;
    @(posedge pclk); presetn <= 1'b1; por_n <= 1'b1;
    @(posedge pclk);
    apb(1'b0, RESET_CTRL_OFS, 32'h0);
  endtask : pulse_rst
  // ****************
  // scenarios
  // ****************
  task t_sleep(input logic dis, input logic [1:0] sel, input int lo, input int hi);
    apb(1'b1, RESET_CTRL_OFS, {23'h0, dis, 8'h0});
    apb(1'b1, CFG_WORD3_OFS, {20'h0, sel, 10'h0});
    evt.sleep_req <= 1'b1; @(posedge pclk); evt.sleep_req <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(exec_enable === 1'b0 && regulator_standby === !dis, "sleep");
    evt.wake_evt <= 1'b1; @(posedge pclk); evt.wake_evt <= 1'b0;
    wexec;
    chk(n >= lo && n <= hi, "wake time");
    $display("sleep test done");
  endtask : t_sleep
  task t_flags;
    evt.low_volt <= 1'b1; @(posedge pclk); evt.low_volt <= 1'b0;
    apb(1'b0, INT_FLAG4_OFS, 32'h0);
    chk(rd[LOW_VOLT_BIT] === 1'b1, "lv set");
    apb(1'b1, INT_FLAG4_OFS, 32'h0);
    apb(1'b0, INT_FLAG4_OFS, 32'h0);
    chk(rd === 32'h0, "lv clear");
    evt.brownout <= 1'b1; @(posedge pclk); evt.brownout <= 1'b0;
    n = 0;
    repeat (3) begin @(posedge pclk); n += (brownout_reset === 1'b1); end
    chk(n == 1, "bor pulse");
    chk(exec_enable === 1'b0, "bor resettle");
    apb(1'b0, RESET_CTRL_OFS, 32'h0);
    chk(rd[BROWNOUT_BIT] === 1'b1, "bor flag");
    pulse_rst(1'b0);
    chk(rd[BROWNOUT_BIT] === 1'b1, "bor kept");
    pulse_rst(1'b1);
    chk(rd === 32'h0, "bor cleared");
    $display("flag test done");
  endtask : t_flags
  task test_done;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
    begin
      $display("Simulation passed");
    end
    else
    begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done
  // ****************
  // main
  // ****************
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 5000) begin errors++; test_done; end
  end
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1; por_n <= 1'b1;
    @(posedge pclk);
    apb(1'b0, RESET_CTRL_OFS, 32'h0);
    chk(rd === 32'h0, "ctl reset");
    apb(1'b0, CFG_WORD3_OFS, 32'h0);
    chk(rd === 32'h0000_0c00, "cfg reset");
    apb(1'b0, 12'h010, 32'h0);
    chk(er === 1'b1 && rd === 32'h0, "unmapped");
    chk(exec_enable === 1'b0 && regulator_on === 1'b0, "strap off");
    regulator_enable_strap <= 1'b1; @(posedge pclk);
    wexec;
    chk(n >= 3 && n <= 8, "settle");
    t_sleep(1'b0, 2'h1, 3, 7);
    t_sleep(1'b0, 2'h3, 8, 13);
    t_sleep(1'b1, 2'h3, 0, 3);
    t_flags;
    test_done;
  end
endmodule : test_crw_sequencer
